/* File: hdl/tipw_consts.vh */
`ifndef TIPW_CONSTS_VH
`define TIPW_CONSTS_VH
// Timing
`define CLK_HZ 25000000
`define CLK_PS 40000
`define RES_FINE_PS 100
`define CYC_UNITS (`CLK_PS / `RES_FINE_PS)
`define AVG_GATES 100
`define SS_MIN_NS 1
`define PW_MIN_NS 5
`define SS_MAX_S 15000
`define AVG_MAX_S 1500
`define PW_MAX_NS 1000000
`define SS_MAX_CYC (40'd1 * `SS_MAX_S * `CLK_HZ)
`define AVG_MAX_CYC (40'd1 * `AVG_MAX_S * `CLK_HZ)
`define PW_MAX_CYC (40'd1 * `PW_MAX_NS * (`CLK_HZ / 1000000) / 1000)
// Register byte offsets
`define A_CTRL 8'h00
`define A_LVL1 8'h04
`define A_LVL2 8'h08
`define A_STAT 8'h0c
`define A_RES_LO 8'h10
`define A_RES_HI 8'h14
`define A_GATES 8'h18
// Control fields
`define C_START 0
`define C_RST 1
`define C_FUNC 2
`define C_PWCH 4
`define C_SLP1 5
`define C_SLP2 6
`define C_FINE 7
`define C_AUTO 8
`define CTRL_RST 9'h160
// Functions
`define F_TINT 2'h0
`define F_PPW 2'h1
`define F_NPW 2'h2
// Status fields
`define S_BUSY 0
`define S_DONE 1
`define S_OVF 2
`define S_AVG 3
// Levels in 2.5 mV steps
`define LVL_MAX 4080
`define LVL_RST 13'h0000
`endif

/* File: hdl/tipw_counter.v */
// Behaviour
// (RQ1) Interval timing starts on channel 1 event, stops on channel 2 event.
// (RQ2) Start and stop edges each programmable rising or falling.
// (RQ3) Single-shot intervals span 1 ns up to 15000 s.
// (RQ4) With 100-gate averaging the longest accepted interval is 1500 s.
// (RQ5) Finest resolution 100 ps; finer than 1 ns forces 100-gate averaging.
// (RQ6) Default resolution 1 ns gives one measurement, no averaging.
// (RQ7) Measurement waits without timeout for the stop edge.
// (RQ8) Overflow flagged in status when a result exceeds the function range.
// (RQ9) Pulse width measured only on the selected channel 1 or 2.
// (RQ10) Positive width: rising edge start, following falling edge stop.
// (RQ11) Negative width: falling edge start, following rising edge stop.
// (RQ12) Pulse width threshold defaults midway between observed peaks.
// (RQ13) Pulse widths span 5 ns up to 1 ms.
// (RQ14) 100 ps resolution for pulse width enables 100-gate averaging.
// (RQ15) Pulse width edges follow polarity, channel slope setting ignored.
// (RQ16) Completed result lands in the output buffer for the controller.
// (RQ17) Reset command restores slopes, levels, resolution, averaging defaults.
// (RQ18) Levels 1 and 2 within +-10.2 V in 2.5 mV; level 3 zero.
// (RQ19) Time measured by counting reference cycles, scaled to time units.
// (RQ20) Averaging accumulates 100 gates and reports their mean.
`timescale 1ns/1ps
`default_nettype none
`include "tipw_consts.vh"
module tipw_counter #(
  parameter [39:0] ss_max_cyc = `SS_MAX_CYC,
  parameter [39:0] avg_max_cyc = `AVG_MAX_CYC,
  parameter [39:0] pw_max_cyc = `PW_MAX_CYC
)(
  // System
  input wire sys_clk,
  input wire nrst,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Comparator outputs
  input wire ch1_cmp,
  input wire ch2_cmp,
  // Observed signal peaks, 2.5 mV steps
  input wire [12:0] pk_hi1,
  input wire [12:0] pk_lo1,
  input wire [12:0] pk_hi2,
  input wire [12:0] pk_lo2,
  // Threshold DAC codes
  output reg [12:0] thr1_o,
  output reg [12:0] thr2_o,
  output reg [12:0] thr3_o
);

localparam [1:0] ST_IDLE = 2'd0;
localparam [1:0] ST_ARM = 2'd1;
localparam [1:0] ST_RUN = 2'd2;
localparam [6:0] ONE_GATE = 7'd1;
localparam [6:0] AVG_GATES = `AVG_GATES;
localparam [39:0] CNT_TOP = 40'hff_ffff_ffff;
localparam [50:0] CYC_MUL = `CYC_UNITS;

////////////////////////////////////////////////////////////////////////
// Input synchronisers
wire [1:0] cmp_in;
wire [25:0] hi_in;
wire [25:0] lo_in;
reg [1:0] cmp_meta;
reg [1:0] cmp_sync;
reg [1:0] cmp_prev;
reg [25:0] hi_meta;
reg [25:0] hi_sync;
reg [25:0] lo_meta;
reg [25:0] lo_sync;
wire [1:0] rise;
wire [1:0] fall;
wire [25:0] mid;

assign cmp_in = {ch2_cmp, ch1_cmp};
assign hi_in = {pk_hi2, pk_hi1};
assign lo_in = {pk_lo2, pk_lo1};

genvar g;
generate
  for (g = 0; g < 2; g = g + 1) begin : chan
    wire [13:0] psum;
    always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
        cmp_meta[g] <= 1'b0;
        cmp_sync[g] <= 1'b0;
        cmp_prev[g] <= 1'b0;
        hi_meta[g*13 +: 13] <= 13'h0000;
        hi_sync[g*13 +: 13] <= 13'h0000;
        lo_meta[g*13 +: 13] <= 13'h0000;
        lo_sync[g*13 +: 13] <= 13'h0000;
      end else begin
        cmp_meta[g] <= cmp_in[g];
        cmp_sync[g] <= cmp_meta[g];
        cmp_prev[g] <= cmp_sync[g];
        hi_meta[g*13 +: 13] <= hi_in[g*13 +: 13];
        hi_sync[g*13 +: 13] <= hi_meta[g*13 +: 13];
        lo_meta[g*13 +: 13] <= lo_in[g*13 +: 13];
        lo_sync[g*13 +: 13] <= lo_meta[g*13 +: 13];
      end
    end
    assign rise[g] = cmp_sync[g] & ~cmp_prev[g];
    assign fall[g] = ~cmp_sync[g] & cmp_prev[g];
    // Midpoint of the two peaks
    assign psum = {hi_sync[g*13+12], hi_sync[g*13 +: 13]} +
                  {lo_sync[g*13+12], lo_sync[g*13 +: 13]};
    assign mid[g*13 +: 13] = psum[13:1]; // RQ12
  end
endgenerate

////////////////////////////////////////////////////////////////////////
// Register file
reg [8:0] ctrl_reg;
reg [12:0] lvl1_reg;
reg [12:0] lvl2_reg;
reg [1:0] st_reg;
reg [39:0] cnt_reg;
reg [41:0] sum_reg;
reg [6:0] gate_reg;
reg [47:0] res_reg;
reg done_reg;
reg ovf_reg;
reg [31:0] rd_next;

wire req;
wire wr;
wire wr_ctrl;
wire start_cmd;
wire rst_cmd;
wire [15:0] ctrl_wd;
wire [1:0] func;
wire pw_mode;
wire avg;
wire [6:0] ngates;
wire [39:0] lim;
wire start_ev;
wire stop_ev;
wire [1:0] pw_sel;
wire [41:0] sum_fin;
wire [50:0] res_prod;
wire last_gate;
wire complete;
wire rd_hi;

function [15:0] merge16;
  input [15:0] old;
  input [15:0] nw;
  input [1:0] sel;
  begin
    merge16 = {sel[1] ? nw[15:8] : old[15:8], sel[0] ? nw[7:0] : old[7:0]};
  end
endfunction

function [12:0] clamp;
  input [15:0] v;
  begin
    if ($signed(v) > $signed(16'd`LVL_MAX))
      clamp = 13'd`LVL_MAX;
    else if ($signed(v) < -$signed(16'd`LVL_MAX))
      clamp = -13'd`LVL_MAX;
    else
      clamp = v[12:0];
  end
endfunction

assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
assign wr = req & wb_we_i;
assign wr_ctrl = wr && wb_adr_i == `A_CTRL;
assign ctrl_wd = merge16({7'h00, ctrl_reg}, wb_dat_i[15:0], wb_sel_i[1:0]);
assign start_cmd = wr_ctrl & wb_sel_i[0] & wb_dat_i[`C_START];
assign rst_cmd = wr_ctrl & wb_sel_i[0] & wb_dat_i[`C_RST];
assign rd_hi = req && !wb_we_i && wb_adr_i == `A_RES_HI;

always @(posedge sys_clk or negedge nrst) begin
  if (!nrst) begin
    ctrl_reg <= `CTRL_RST;
    lvl1_reg <= `LVL_RST;
    lvl2_reg <= `LVL_RST;
  end else if (rst_cmd) begin
    ctrl_reg <= `CTRL_RST; // RQ17
    lvl1_reg <= `LVL_RST; // RQ17
    lvl2_reg <= `LVL_RST;
  end else if (wr) begin
    if (wb_adr_i == `A_CTRL)
      ctrl_reg <= {ctrl_wd[8:2], 2'b00};
    if (wb_adr_i == `A_LVL1)
      lvl1_reg <= clamp(merge16({{3{lvl1_reg[12]}}, lvl1_reg},
                                wb_dat_i[15:0], wb_sel_i[1:0])); // RQ18
    if (wb_adr_i == `A_LVL2)
      lvl2_reg <= clamp(merge16({{3{lvl2_reg[12]}}, lvl2_reg},
                                wb_dat_i[15:0], wb_sel_i[1:0])); // RQ18
  end
end

always @* begin
  case (wb_adr_i)
    `A_CTRL: rd_next = {23'h00_0000, ctrl_reg};
    `A_LVL1: rd_next = {{19{lvl1_reg[12]}}, lvl1_reg};
    `A_LVL2: rd_next = {{19{lvl2_reg[12]}}, lvl2_reg};
    `A_STAT: rd_next = {28'h000_0000, avg, ovf_reg, done_reg, st_reg != ST_IDLE};
    `A_RES_LO: rd_next = res_reg[31:0];
    `A_RES_HI: rd_next = {16'h0000, res_reg[47:32]};
    `A_GATES: rd_next = {25'h000_0000, gate_reg};
    default: rd_next = 32'h0000_0000;
  endcase
end

always @(posedge sys_clk or negedge nrst) begin
  if (!nrst) begin
    wb_ack_o <= 1'b0;
    wb_dat_o <= 32'h0000_0000;
  end else begin
    wb_ack_o <= req;
    // Read data holds until the next read
    if (req && !wb_we_i)
      wb_dat_o <= rd_next;
  end
end

////////////////////////////////////////////////////////////////////////
// Edge qualification
assign func = ctrl_reg[`C_FUNC +: 2];
assign pw_mode = func == `F_PPW || func == `F_NPW;
assign avg = ctrl_reg[`C_FINE]; // RQ5 RQ14
assign ngates = avg ? AVG_GATES : ONE_GATE; // RQ6 RQ20
assign pw_sel = ctrl_reg[`C_PWCH] ? 2'b10 : 2'b01; // RQ9
// Range limit of the active function
assign lim = pw_mode ? pw_max_cyc : (avg ? avg_max_cyc : ss_max_cyc); // RQ3 RQ4 RQ13

// Polarity picks edges in pulse mode; slopes are ignored there
assign start_ev = pw_mode ?
  (|(pw_sel & (func == `F_PPW ? rise : fall))) : // RQ10 RQ11 RQ15
  (ctrl_reg[`C_SLP1] ? rise[0] : fall[0]); // RQ1 RQ2
assign stop_ev = pw_mode ?
  (|(pw_sel & (func == `F_PPW ? fall : rise))) : // RQ10 RQ11 RQ15
  (ctrl_reg[`C_SLP2] ? rise[1] : fall[1]); // RQ1 RQ2

////////////////////////////////////////////////////////////////////////
// Measurement sequencer
assign sum_fin = sum_reg + {2'b00, cnt_reg} + 42'd1;
// Averaged mean in 100 ps units is sum times 400 / 100
assign res_prod = avg ? {9'h000, sum_fin} * CYC_MUL / 51'd`AVG_GATES :
                        {9'h000, sum_fin} * CYC_MUL; // RQ19 RQ20
assign last_gate = gate_reg + ONE_GATE >= ngates;
assign complete = st_reg == ST_RUN && stop_ev && last_gate;

always @(posedge sys_clk or negedge nrst) begin
  if (!nrst) begin
    st_reg <= ST_IDLE;
    cnt_reg <= 40'h00_0000_0000;
    sum_reg <= 42'h000_0000_0000;
    gate_reg <= 7'h00;
    res_reg <= 48'h0000_0000_0000;
    ovf_reg <= 1'b0;
  end else if (rst_cmd) begin
    st_reg <= ST_IDLE;
    ovf_reg <= 1'b0;
  end else if (start_cmd) begin
    st_reg <= ST_ARM;
    sum_reg <= 42'h000_0000_0000;
    gate_reg <= 7'h00;
    ovf_reg <= 1'b0;
  end else begin
    case (st_reg)
      ST_IDLE: begin
        st_reg <= ST_IDLE;
      end
      ST_ARM: begin
        if (start_ev) begin
          cnt_reg <= 40'h00_0000_0000;
          st_reg <= ST_RUN;
        end
      end
      ST_RUN: begin
        // No timeout: only the stop edge, a reset command or a start command ends the gate
        if (cnt_reg != CNT_TOP)
          cnt_reg <= cnt_reg + 40'd1; // RQ7 RQ19
        if (cnt_reg >= lim)
          ovf_reg <= 1'b1; // RQ8
        if (stop_ev) begin
          sum_reg <= sum_fin; // RQ20
          gate_reg <= gate_reg + ONE_GATE;
          if (last_gate) begin
            res_reg <= res_prod[47:0]; // RQ16
            st_reg <= ST_IDLE;
          end else begin
            st_reg <= ST_ARM;
          end
        end
      end
      default: begin
        st_reg <= ST_IDLE;
      end
    endcase
  end
end

// Done flag: completion wins over the clear by a result read
always @(posedge sys_clk or negedge nrst) begin
  if (!nrst)
    done_reg <= 1'b0;
  else if (complete && !rst_cmd && !start_cmd)
    done_reg <= 1'b1; // RQ16
  else if (rd_hi || start_cmd || rst_cmd)
    done_reg <= 1'b0;
end

////////////////////////////////////////////////////////////////////////
// Threshold outputs
always @(posedge sys_clk or negedge nrst) begin
  if (!nrst) begin
    thr1_o <= 13'h0000;
    thr2_o <= 13'h0000;
    thr3_o <= 13'h0000;
  end else begin
    thr1_o <= (pw_mode && ctrl_reg[`C_AUTO] && pw_sel[0]) ?
              mid[12:0] : lvl1_reg; // RQ12 RQ18
    thr2_o <= (pw_mode && ctrl_reg[`C_AUTO] && pw_sel[1]) ?
              mid[25:13] : lvl2_reg; // RQ12 RQ18
    thr3_o <= 13'h0000; // RQ18
  end
end

endmodule
`default_nettype wire

/* File: verif/tipw_counter_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module tipw_counter_properties (
  // Clock and reset
  input wire sys_clk,
  input wire nrst,
  // Bus
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire wb_dat_i_b1,
  input wire wb_sel_i_b0,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  // Thresholds
  input wire [12:0] thr1_o,
  input wire [12:0] thr2_o,
  input wire [12:0] thr3_o
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////////
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_lat_a: assert property ($rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o)
    else $error("ack not one cycle after request");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  read_hold_a: assert property ($changed(wb_dat_o) |-> wb_ack_o && !$past(wb_we_i))
    else $error("read data changed outside a read");
  unmapped_read_a: assert property (wb_ack_o && $past(!wb_we_i && wb_adr_i >= 8'h1c)
    |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
  rst_cmd_a: assert property (wb_ack_o && $past(wb_we_i && wb_adr_i == 8'h00 && wb_dat_i_b1
    && wb_sel_i_b0) |=> thr1_o == 13'h0 && thr2_o == 13'h0)
    else $error("levels kept after reset command");
  thr_range_a: assert property ($signed(thr1_o) <= 4080 && $signed(thr1_o) >= -4080)
    else $error("threshold out of range");
  thr3_zero_a: assert property (thr3_o == 13'h0)
    else $error("third threshold not zero");
  ////////////////////////////////////////////////////////////////////////////////
  cover property (wb_ack_o && $past(wb_we_i));
  cover property (thr1_o != 13'h0);
  cover property (wb_ack_o && $past(!wb_we_i && wb_adr_i >= 8'h1c));
endmodule
`default_nettype wire

/* File: verif/tipw_comparators.sv */
`timescale 1ns/1ps
`default_nettype none
module tipw_comparators (
  // Clock
  input wire sys_clk,
  // Comparator outputs
  output logic ch1_cmp,
  output logic ch2_cmp,
  // Peaks, auto level works out to 40 on channel 1 and 100 on channel 2
  output logic [12:0] pk_hi1,
  output logic [12:0] pk_lo1,
  output logic [12:0] pk_hi2,
  output logic [12:0] pk_lo2
);
  initial begin
    ch1_cmp = 1'b1;
    ch2_cmp = 1'b0;
    pk_hi1 = 13'd100;
    pk_lo1 = -13'sd20;
    pk_hi2 = 13'd200;
    pk_lo2 = 13'd0;
  end
  // Edges land just after a clock edge
  task drive(input logic [1:0] v, input int gap);
    repeat (gap) @(posedge sys_clk);
    {ch2_cmp, ch1_cmp} <= v;
  endtask
endmodule
`default_nettype wire

/* File: verif/tipw_counter_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module tipw_counter_bench;
  logic sys_clk, nrst, wb_cyc_i, wb_stb_i, wb_we_i;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, q;
  wire [31:0] wb_dat_o;
  wire wb_ack_o, ch1_cmp, ch2_cmp;
  wire [12:0] pk_hi1, pk_lo1, pk_hi2, pk_lo2, thr1_o, thr2_o, thr3_o;
  int num_errors = 0;
  int tests_run = 0;
  tipw_counter #(.pw_max_cyc(40'd20)) dut_u (.sys_clk, .nrst, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .ch1_cmp, .ch2_cmp,
    .pk_hi1, .pk_lo1, .pk_hi2, .pk_lo2, .thr1_o, .thr2_o, .thr3_o);
  tipw_comparators cmp_u (.sys_clk, .ch1_cmp, .ch2_cmp, .pk_hi1, .pk_lo1, .pk_hi2, .pk_lo2);
  ////////////////////////////////////////////////////////////////////////////////
  task finish_test;
    $display("Errors %0d, checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge sys_clk);
    while (wb_ack_o !== 1'b1 && n < 20) begin
      n++;
      @(posedge sys_clk);
    end
    chk(n < 20, 1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge sys_clk);
  endtask
  // Poll for done, then read the two result words
  task result(input logic [31:0] lo, input logic [31:0] st);
    int n;
    q = 0;
    for (n = 0; n < 200 && q[1] !== 1'b1; n++) wb(0, 8'h0c, 0);
    chk(q & st, st);
    wb(0, 8'h10, 0);
    chk(q, lo);
    wb(0, 8'h14, 0);
    chk(q, 0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task t_regs;
    wb(0, 8'h00, 0);
    chk(q, 32'h160);
    wb(1, 8'h04, 32'h1388);
    wb(0, 8'h04, 0);
    chk(q, 32'hff0);
    chk({19'h0, thr1_o}, 32'hff0);
    wb(1, 8'h08, 32'hff9c);
    wb(0, 8'h08, 0);
    chk(q, 32'hffff_ff9c);
    chk({19'h0, thr2_o}, 32'h1f9c);
    chk({19'h0, thr3_o}, 32'h0);
    wb(1, 8'h0c, 32'hf);
    wb(0, 8'h0c, 0);
    chk(q, 0);
    wb(0, 8'h1c, 0);
    chk(q, 0);
    wb(1, 8'h00, 32'h2);
    wb(0, 8'h00, 0);
    chk(q, 32'h160);
    wb(0, 8'h04, 0);
    chk(q, 0);
  endtask
  task t_tint;
    wb(1, 8'h00, 32'h41);
    cmp_u.drive(2'b11, 2);
    cmp_u.drive(2'b01, 2);
    cmp_u.drive(2'b00, 3);
    cmp_u.drive(2'b10, 10);
    result(32'd4000, 32'h2);
    wb(0, 8'h18, 0);
    chk(q, 1);
  endtask
  task t_pw;
    cmp_u.drive(2'b00, 1);
    wb(1, 8'h00, 32'h15);
    cmp_u.drive(2'b01, 2);
    cmp_u.drive(2'b11, 2);
    cmp_u.drive(2'b01, 25);
    result(32'd10000, 32'h6);
  endtask
  task t_avg;
    int i;
    wb(1, 8'h00, 32'h189);
    wb(0, 8'h0c, 0);
    chk(q & 32'h9, 32'h9);
    chk({19'h0, thr1_o}, 32'd40);
    for (i = 0; i < 100; i++) begin
      cmp_u.drive(2'b00, 3);
      cmp_u.drive(2'b01, 5);
    end
    result(32'd2000, 32'h2);
    wb(0, 8'h18, 0);
    chk(q, 100);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  initial begin
    #800000;
    num_errors++;
    finish_test;
  end
  initial begin
    nrst = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h0;
    wb_sel_i = 4'hf;
    wb_dat_i = 32'h0;
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    t_regs;
    t_tint;
    t_pw;
    t_avg;
    finish_test;
  end
endmodule
bind tipw_counter tipw_counter_properties chk_u (.sys_clk, .nrst, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_dat_i_b1(wb_dat_i[1]), .wb_sel_i_b0(wb_sel_i[0]), .wb_dat_o,
  .wb_ack_o, .thr1_o, .thr2_o, .thr3_o);
`default_nettype wire
